// ==== lfp_map.vh ====
`ifndef LFP_MAP_VH
`define LFP_MAP_VH

// ****************************************************************
// Geometry and timing
// ****************************************************************
`define LFP_NFLOOR          8
`define LFP_FW              3
`define LFP_CLK_HZ          10000000
`define LFP_PARK_DELAY_S    10
`define LFP_PARK_DELAY_CYC  (`LFP_PARK_DELAY_S * `LFP_CLK_HZ)
`define LFP_TMR_W           27

// ****************************************************************
// Reset values of the user-side outputs
// ****************************************************************
`define LFP_RST_LIGHT       1'b1
`define LFP_RST_DISP        1'b1
`define LFP_RST_HALL_EN     1'b1
`define LFP_RST_CAR_EN      1'b1

`endif

// ==== lfp_delay.v ====
`timescale 1ns/100ps

// ****************************************************************
// Restartable one-shot delay
// ****************************************************************
module lfp_delay #(
  parameter          CW    = 27,
  parameter [CW-1:0] COUNT = 27'd100000000
) (
  input  wire clk_sys_i,
  input  wire arst_n_i,
  input  wire start_i,
  input  wire stop_i,
  output reg  done_o
);

  reg [CW-1:0] cnt_q;
  reg          run_q;

  // A start while running reloads the count, so every button press
  // buys a fresh full delay.
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q  <= {CW{1'b0}};
      run_q  <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (stop_i) begin
        run_q <= 1'b0;
      end else if (start_i) begin
        cnt_q <= COUNT - {{(CW-1){1'b0}}, 1'b1};
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q == {CW{1'b0}}) begin
          run_q  <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // lfp_delay

// ==== lfp_mode_ctrl.v ====
// Operation
// - Fire switch closing enters fire mode and clears all landing and car calls.
// - Fire mode drives the car to the fire floor and holds the door open there.
// - Fire linkage output asserts only after the car reaches the fire floor.
// - Car running away from fire floor stops at nearest floor, door shut, then returns.
// - Fire option 1 stops all further running at the fire floor.
// - Fire option 0 ignores landing calls, door held open at the fire floor.
// - Option 0: held close button closes door and runs; early release reopens.
// - Option 0 arrival: held open button opens door; early release closes again.
// - Option 0 accepts just one target floor per run.
// - Fault outside landing zone crawls toward middle floor to leveling zone, opens door.
// - Rescue crawl runs only with safety circuit and inverter both healthy.
// - Lock closed: park mode, drop landing calls, serve car calls, go to park floor.
// - No car calls at park entry sends the car straight to the park floor.
// - Parked: show parking sign on hall and car panels, ignore every call.
// - Ten seconds after parking, close door, car light and displays off.
// - While parked, car or door buttons switch the car light back on.
// - After a door button while parked, close door and light off after ten seconds.
// - Inspection at lock closing skips the return trip, other parking behaviour kept.
// - Opening the lock leaves parking mode and resumes normal service.
`timescale 1ns/100ps
`include "lfp_map.vh"

module lfp_mode_ctrl #(
  parameter NFL            = `LFP_NFLOOR,
  parameter FW             = `LFP_FW,
  parameter PARK_DELAY_CYC = `LFP_PARK_DELAY_CYC
) (
  input  wire          clk_sys_i,
  input  wire          arst_n_i,
  input  wire          fire_sw_i,
  input  wire          fire_opt_i,
  input  wire          park_lock_i,
  input  wire          insp_i,
  input  wire          fault_i,
  input  wire          safety_ok_i,
  input  wire          inv_ok_i,
  input  wire          in_zone_i,
  input  wire          car_moving_i,
  input  wire          car_dir_up_i,
  input  wire [FW-1:0] car_floor_i,
  input  wire [FW-1:0] fire_floor_i,
  input  wire [FW-1:0] park_floor_i,
  input  wire [FW-1:0] mid_floor_i,
  input  wire          car_call_pend_i,
  input  wire [NFL-1:0] car_btn_i,
  input  wire          door_open_btn_i,
  input  wire          door_close_btn_i,
  input  wire          door_opened_i,
  input  wire          door_closed_i,
  output reg           clear_calls_o,
  output reg           hall_call_en_o,
  output reg           car_call_en_o,
  output reg           run_o,
  output reg  [FW-1:0] run_tgt_o,
  output reg           stop_near_o,
  output reg           crawl_o,
  output reg           crawl_up_o,
  output reg           door_open_o,
  output reg           door_close_o,
  output reg           fire_mode_o,
  output reg           fire_link_o,
  output reg           park_mode_o,
  output reg           parking_display_sign_o,
  output reg           car_light_o,
  output reg           disp_on_o
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam NS        = 13;
  localparam [NS-1:0] S_NORMAL    = 13'h0001;
  localparam [NS-1:0] S_FIRE_STOP = 13'h0002;
  localparam [NS-1:0] S_FIRE_RET  = 13'h0004;
  localparam [NS-1:0] S_FIRE_DONE = 13'h0008;
  localparam [NS-1:0] S_FIRE_HOLD = 13'h0010;
  localparam [NS-1:0] S_FIRE_CLS  = 13'h0020;
  localparam [NS-1:0] S_FIRE_RUN  = 13'h0040;
  localparam [NS-1:0] S_FIRE_ARR  = 13'h0080;
  localparam [NS-1:0] S_FIRE_OPN  = 13'h0100;
  localparam [NS-1:0] S_RESCUE    = 13'h0200;
  localparam [NS-1:0] S_PARK_SRV  = 13'h0400;
  localparam [NS-1:0] S_PARK_RET  = 13'h0800;
  localparam [NS-1:0] S_PARK_IDLE = 13'h1000;
  localparam [`LFP_TMR_W-1:0] DLY = PARK_DELAY_CYC[`LFP_TMR_W-1:0];

  reg [NS-1:0] state_q;
  reg [NS-1:0] state_d;
  reg [FW-1:0] tgt_q;
  reg [FW-1:0] tgt_d;
  reg          tgt_vld_q;
  reg          tgt_vld_d;
  reg          noret_q;
  reg          noret_d;
  reg          fire_q;
  reg          btn_any;
  reg [FW-1:0] btn_floor;
  reg [31:0]   idx;
  integer      i;

  wire fire_rise  = fire_sw_i & ~fire_q;
  wire stopped    = ~car_moving_i & in_zone_i;
  wire at_tgt     = stopped & (car_floor_i == tgt_q);
  wire away       = car_moving_i & (car_dir_up_i ? (fire_floor_i < car_floor_i)
                                                 : (fire_floor_i > car_floor_i));
  wire door_btn   = door_open_btn_i | door_close_btn_i;
  wire park_press = door_btn | (|car_btn_i);
  wire entering_idle = (state_d == S_PARK_IDLE) & (state_q != S_PARK_IDLE);
  wire tmr_done;

  // ****************************************************************
  // Target floor picked from the car buttons
  // ****************************************************************
  always @* begin
    btn_any   = 1'b0;
    btn_floor = {FW{1'b0}};
    idx       = 32'h0000_0000;
    for (i = NFL - 1; i >= 0; i = i - 1) begin
      if (car_btn_i[i]) begin
        btn_any   = 1'b1;
        idx       = i;
        btn_floor = idx[FW-1:0];
      end
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always @* begin
    state_d   = state_q;
    tgt_d     = tgt_q;
    tgt_vld_d = tgt_vld_q;
    noret_d   = noret_q;
    if (fire_rise) begin
      tgt_d     = fire_floor_i;
      tgt_vld_d = 1'b0;
      state_d   = away ? S_FIRE_STOP : S_FIRE_RET;
    end else if (!fire_sw_i && (state_q & (S_FIRE_STOP | S_FIRE_RET | S_FIRE_DONE |
                 S_FIRE_HOLD | S_FIRE_CLS | S_FIRE_RUN | S_FIRE_ARR | S_FIRE_OPN))
                 != {NS{1'b0}}) begin
      state_d = S_NORMAL;
    end else if (!park_lock_i && (state_q & (S_PARK_SRV | S_PARK_RET | S_PARK_IDLE))
                 != {NS{1'b0}}) begin
      state_d = S_NORMAL;
    end else begin
      case (state_q)
        S_NORMAL: begin
          if (park_lock_i && !fire_sw_i) begin
            state_d = S_PARK_SRV;
            noret_d = insp_i;
          end else if (fault_i && !in_zone_i && !car_moving_i && safety_ok_i && inv_ok_i) begin
            state_d = S_RESCUE;
          end
        end
        S_RESCUE: begin
          if (!fault_i) begin
            state_d = S_NORMAL;
          end
        end
        S_FIRE_STOP: begin
          if (stopped) begin
            state_d = S_FIRE_RET;
          end
        end
        S_FIRE_RET: begin
          if (at_tgt) begin
            state_d = fire_opt_i ? S_FIRE_DONE : S_FIRE_HOLD;
          end
        end
        S_FIRE_HOLD: begin
          if (!tgt_vld_q && btn_any && btn_floor != car_floor_i) begin
            tgt_d     = btn_floor;
            tgt_vld_d = 1'b1;
          end else if (tgt_vld_q && door_close_btn_i) begin
            state_d = S_FIRE_CLS;
          end
        end
        S_FIRE_CLS: begin
          if (!door_close_btn_i) begin
            state_d = S_FIRE_HOLD;
          end else if (door_closed_i) begin
            state_d = S_FIRE_RUN;
          end
        end
        S_FIRE_RUN: begin
          if (at_tgt) begin
            state_d   = S_FIRE_ARR;
            tgt_vld_d = 1'b0;
          end
        end
        S_FIRE_ARR: begin
          if (door_open_btn_i) begin
            state_d = S_FIRE_OPN;
          end
        end
        S_FIRE_OPN: begin
          if (!door_open_btn_i) begin
            state_d = S_FIRE_ARR;
          end else if (door_opened_i) begin
            state_d = S_FIRE_HOLD;
          end
        end
        S_PARK_SRV: begin
          if (!car_call_pend_i && stopped) begin
            if (noret_q) begin
              state_d = S_PARK_IDLE;
            end else begin
              tgt_d   = park_floor_i;
              state_d = S_PARK_RET;
            end
          end
        end
        S_PARK_RET: begin
          if (at_tgt) begin
            state_d = S_PARK_IDLE;
          end
        end
        S_PARK_IDLE: begin
          state_d = S_PARK_IDLE;
        end
        S_FIRE_DONE: begin
          state_d = S_FIRE_DONE;
        end
        default: begin
          state_d = S_NORMAL;
        end
      endcase
    end
  end

  // ****************************************************************
  // Parking delay
  // ****************************************************************
  // Car buttons restart the delay as well, otherwise a light switched
  // back on by a car button would never go out again.
  lfp_delay #(
    .CW    (`LFP_TMR_W),
    .COUNT (DLY)
  ) u_park_dly (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .start_i   (entering_idle | (state_q == S_PARK_IDLE && park_press)),
    .stop_i    (state_q != S_PARK_IDLE && !entering_idle),
    .done_o    (tmr_done)
  );

  // ****************************************************************
  // State and registered outputs
  // ****************************************************************
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q                <= S_NORMAL;
      tgt_q                  <= {FW{1'b0}};
      tgt_vld_q              <= 1'b0;
      noret_q                <= 1'b0;
      fire_q                 <= 1'b0;
      clear_calls_o          <= 1'b0;
      hall_call_en_o         <= `LFP_RST_HALL_EN;
      car_call_en_o          <= `LFP_RST_CAR_EN;
      run_o                  <= 1'b0;
      run_tgt_o              <= {FW{1'b0}};
      stop_near_o            <= 1'b0;
      crawl_o                <= 1'b0;
      crawl_up_o             <= 1'b0;
      door_open_o            <= 1'b0;
      door_close_o           <= 1'b0;
      fire_mode_o            <= 1'b0;
      fire_link_o            <= 1'b0;
      park_mode_o            <= 1'b0;
      parking_display_sign_o <= 1'b0;
      car_light_o            <= `LFP_RST_LIGHT;
      disp_on_o              <= `LFP_RST_DISP;
    end else begin
      state_q       <= state_d;
      tgt_q         <= tgt_d;
      tgt_vld_q     <= tgt_vld_d;
      noret_q       <= noret_d;
      fire_q        <= fire_sw_i;
      clear_calls_o <= fire_rise;
      fire_mode_o   <= ~state_d[0] & (state_d & (S_RESCUE | S_PARK_SRV | S_PARK_RET |
                       S_PARK_IDLE)) == {NS{1'b0}};
      park_mode_o   <= (state_d & (S_PARK_SRV | S_PARK_RET | S_PARK_IDLE)) != {NS{1'b0}};
      // Landing calls only in normal service and rescue; car calls also while parking clears out.
      hall_call_en_o <= (state_d == S_NORMAL) | (state_d == S_RESCUE);
      car_call_en_o  <= (state_d == S_NORMAL) | (state_d == S_RESCUE) |
                        (state_d == S_PARK_SRV);
      run_o          <= (state_d == S_FIRE_RET) | (state_d == S_FIRE_RUN) |
                        (state_d == S_PARK_RET);
      run_tgt_o      <= tgt_d;
      stop_near_o    <= (state_d == S_FIRE_STOP);
      crawl_o        <= (state_d == S_RESCUE) & ~in_zone_i & safety_ok_i & inv_ok_i;
      crawl_up_o     <= (car_floor_i < mid_floor_i);
      // Link stays up from arrival at the fire floor until fire mode ends.
      fire_link_o    <= ~state_d[0] & (fire_link_o | ((state_q == S_FIRE_RET) &
                        (state_d != S_FIRE_RET))) & fire_sw_i;
      case (state_d)
        S_FIRE_DONE, S_FIRE_HOLD, S_FIRE_OPN: begin
          door_open_o  <= 1'b1;
          door_close_o <= 1'b0;
        end
        S_RESCUE: begin
          door_open_o  <= in_zone_i & ~car_moving_i;
          door_close_o <= 1'b0;
        end
        S_FIRE_STOP, S_FIRE_RET, S_FIRE_CLS, S_FIRE_RUN, S_FIRE_ARR, S_PARK_RET: begin
          door_open_o  <= 1'b0;
          door_close_o <= 1'b1;
        end
        S_PARK_IDLE: begin
          if (entering_idle || (door_open_btn_i && !tmr_done)) begin
            door_open_o  <= 1'b1;
            door_close_o <= 1'b0;
          end else if (tmr_done || door_close_btn_i) begin
            door_open_o  <= 1'b0;
            door_close_o <= 1'b1;
          end
        end
        default: begin
          door_open_o  <= 1'b0;
          door_close_o <= 1'b0;
        end
      endcase
      if (state_d == S_PARK_IDLE) begin
        parking_display_sign_o <= 1'b1;
        if (entering_idle) begin
          car_light_o <= 1'b1;
          disp_on_o   <= 1'b1;
        end else if (park_press) begin
          car_light_o <= 1'b1;
        end else if (tmr_done) begin
          car_light_o <= 1'b0;
          disp_on_o   <= 1'b0;
        end
      end else begin
        parking_display_sign_o <= 1'b0;
        car_light_o            <= 1'b1;
        disp_on_o              <= 1'b1;
      end
    end
  end

endmodule // lfp_mode_ctrl

// ==== lfp_mode_ctrl_properties.sv ====
`timescale 1ns/100ps
module lfp_mode_ctrl_props #(
  parameter PARK_DELAY_CYC = 50
) (
  input wire       clk_sys_i,
  input wire       arst_n_i,
  input wire       fire_sw_i,
  input wire       park_lock_i,
  input wire       safety_ok_i,
  input wire       inv_ok_i,
  input wire [2:0] car_floor_i,
  input wire [2:0] fire_floor_i,
  input wire [7:0] car_btn_i,
  input wire       door_open_btn_i,
  input wire       door_close_btn_i,
  input wire       clear_calls_o,
  input wire       hall_call_en_o,
  input wire       run_o,
  input wire       stop_near_o,
  input wire       crawl_o,
  input wire       door_open_o,
  input wire       door_close_o,
  input wire       fire_mode_o,
  input wire       fire_link_o,
  input wire       park_mode_o,
  input wire       parking_display_sign_o,
  input wire       car_light_o,
  input wire       disp_on_o
);
  // ****************************************************************
  // Idle time while parked
  // ****************************************************************
  int  idle_q;
  wire btn_w = |car_btn_i || door_open_btn_i || door_close_btn_i;
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) idle_q <= 0;
    else if (!parking_display_sign_o || btn_w) idle_q <= 0;
    else idle_q <= idle_q + 1;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_fire_entry;
    $rose(fire_sw_i);
  endsequence
  sequence s_fire_answer;
    clear_calls_o && fire_mode_o ##0 (run_o || stop_near_o);
  endsequence

  AST_FIRE_CLEAR: assert property (s_fire_entry |=> s_fire_answer)
    else $error("fire entry without call clear and return");
  AST_FIRE_HALL: assert property (fire_mode_o |-> !hall_call_en_o)
    else $error("landing calls accepted in fire mode");
  AST_LINK_FLOOR: assert property ($rose(fire_link_o) |-> $past(car_floor_i) == $past(fire_floor_i))
    else $error("fire linkage away from fire floor");
  AST_DOOR_EXCL: assert property (!(door_open_o && door_close_o))
    else $error("door open and close together");
  AST_CRAWL_SAFE: assert property (crawl_o |-> $past(safety_ok_i && inv_ok_i))
    else $error("crawl without healthy safety and inverter");
  AST_PARK_SIGN: assert property (parking_display_sign_o |-> park_mode_o && !hall_call_en_o)
    else $error("parking sign outside parking");
  AST_PARK_OFF: assert property (idle_q == PARK_DELAY_CYC + 4 |-> !car_light_o && !disp_on_o)
    else $error("light or display still on after park delay");
  AST_LIGHT_KEPT: assert property (idle_q >= 2 && idle_q < PARK_DELAY_CYC - 4 |-> car_light_o)
    else $error("light off before park delay");
  AST_LIGHT_ON: assert property (parking_display_sign_o && btn_w |=> car_light_o)
    else $error("button did not light the car");
  AST_LOCK_EXIT: assert property ($fell(park_lock_i) |=> !park_mode_o)
    else $error("parking kept after lock opened");
  AST_FIRE_PRIO: assert property (park_mode_o |-> !fire_mode_o)
    else $error("parking and fire modes together");
  AST_FIRE_OVER_PARK: assert property (fire_sw_i && park_lock_i |=> !park_mode_o)
    else $error("parking taken while fire switch closed");
endmodule // lfp_mode_ctrl_props

bind lfp_mode_ctrl lfp_mode_ctrl_props #(.PARK_DELAY_CYC(PARK_DELAY_CYC)) u_props (
  .clk_sys_i, .arst_n_i, .fire_sw_i, .park_lock_i, .safety_ok_i, .inv_ok_i, .car_floor_i,
  .fire_floor_i, .car_btn_i, .door_open_btn_i, .door_close_btn_i, .clear_calls_o,
  .hall_call_en_o, .run_o, .stop_near_o, .crawl_o, .door_open_o, .door_close_o,
  .fire_mode_o, .fire_link_o, .park_mode_o, .parking_display_sign_o, .car_light_o,
  .disp_on_o);

// ==== lfp_car_model.sv ====
`timescale 1ns/100ps
module lfp_car_model #(
  parameter STEP = 4
) (
  input  wire       clk_sys_i,
  input  wire       arst_n_i,
  input  wire       run_i,
  input  wire [2:0] tgt_i,
  input  wire       stop_i,
  input  wire       crawl_i,
  input  wire       sweep_i,
  input  wire       strand_i,
  input  wire       open_i,
  input  wire       close_i,
  output reg  [2:0] floor_o,
  output wire       zone_o,
  output reg        moving_o,
  output reg        up_o,
  output wire       opened_o,
  output wire       closed_o
);
  reg  [3:0] tick_q;
  reg  [2:0] door_q;
  reg        strand_q;
  // A car only starts with the door shut, so a run against an open door stalls.
  wire       go_w = !stop_i && closed_o && (sweep_i || (run_i && floor_o != tgt_i));
  assign zone_o   = !moving_o && !strand_q;
  assign opened_o = door_q == 3'h4;
  assign closed_o = door_q == 3'h0;
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      floor_o  <= 3'h0;
      moving_o <= 1'b0;
      up_o     <= 1'b0;
      tick_q   <= 4'h0;
      door_q   <= 3'h0;
      strand_q <= 1'b0;
    end else begin
      if (open_i && !opened_o) door_q <= door_q + 3'h1;
      // Normal service outside the block shuts the door before a sweep run.
      else if ((close_i || sweep_i) && !closed_o) door_q <= door_q - 3'h1;
      if (moving_o || crawl_i) tick_q <= tick_q + 4'h1;
      if (strand_i) strand_q <= 1'b1;
      else if (crawl_i && tick_q == STEP) strand_q <= 1'b0;
      if (tick_q == STEP) tick_q <= 4'h0;
      if (moving_o && tick_q == STEP) begin
        moving_o <= 1'b0;
        floor_o  <= up_o ? floor_o + 3'h1 : floor_o - 3'h1;
      end else if (!moving_o) begin
        moving_o <= go_w;
        up_o     <= sweep_i || tgt_i > floor_o;
      end
    end
  end
endmodule // lfp_car_model

// ==== test_lfp_mode_ctrl.sv ====
`timescale 1ns/100ps
module test_lfp_mode_ctrl;
  localparam PD = 50;
  reg clk_sys_i = 0, arst_n_i = 0, fire_sw_i = 0, fire_opt_i = 1, park_lock_i = 0, insp_i = 0;
  reg fault_i = 0, safety_ok_i = 1, inv_ok_i = 1, car_call_pend_i = 0, sweep = 0, strand = 0;
  reg door_open_btn_i = 0, door_close_btn_i = 0;
  reg [2:0] fire_floor_i = 3'h0, park_floor_i = 3'h1, mid_floor_i = 3'h4;
  reg [7:0] car_btn_i = 8'h00;
  wire [2:0] car_floor_i, run_tgt_o;
  wire in_zone_i, car_moving_i, car_dir_up_i, door_opened_i, door_closed_i, clear_calls_o;
  wire hall_call_en_o, car_call_en_o, run_o, stop_near_o, crawl_o, crawl_up_o, door_open_o;
  wire door_close_o, fire_mode_o, fire_link_o, park_mode_o, parking_display_sign_o;
  wire car_light_o, disp_on_o;
  int  bad_count = 0, checks = 0, n;
  reg  seen;
  reg  [2:0] fl;

  always #50 clk_sys_i = ~clk_sys_i;

  lfp_mode_ctrl #(.PARK_DELAY_CYC(PD)) uut (.clk_sys_i, .arst_n_i, .fire_sw_i, .fire_opt_i,
    .park_lock_i, .insp_i, .fault_i, .safety_ok_i, .inv_ok_i, .in_zone_i, .car_moving_i,
    .car_dir_up_i, .car_floor_i, .fire_floor_i, .park_floor_i, .mid_floor_i, .car_call_pend_i,
    .car_btn_i, .door_open_btn_i, .door_close_btn_i, .door_opened_i, .door_closed_i,
    .clear_calls_o, .hall_call_en_o, .car_call_en_o, .run_o, .run_tgt_o, .stop_near_o,
    .crawl_o, .crawl_up_o, .door_open_o, .door_close_o, .fire_mode_o, .fire_link_o,
    .park_mode_o, .parking_display_sign_o, .car_light_o, .disp_on_o);

  lfp_car_model u_car (.clk_sys_i, .arst_n_i, .run_i(run_o), .tgt_i(run_tgt_o),
    .stop_i(stop_near_o), .crawl_i(crawl_o), .sweep_i(sweep), .strand_i(strand),
    .open_i(door_open_o), .close_i(door_close_o), .floor_o(car_floor_i), .zone_o(in_zone_i),
    .moving_o(car_moving_i), .up_o(car_dir_up_i), .opened_o(door_opened_i),
    .closed_o(door_closed_i));

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task cyc(input int k);
    repeat (k) @(negedge clk_sys_i);
  endtask

  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task give_verdict;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task fire_return;
    fire_sw_i = 1;
    for (n = 0; n < 5 && fire_mode_o !== 1'b1; n++) cyc(1);
    chk("clear", 1, clear_calls_o);
    chk("hall_en", 0, hall_call_en_o);
    for (n = 0; n < 50 && fire_link_o !== 1'b1; n++) cyc(1);
    chk("link", 1, fire_link_o);
    cyc(10);
    chk("door_open", 1, door_open_o);
    chk("run", 0, run_o);
    fire_sw_i = 0;
    cyc(3);
    chk("fire_mode", 0, fire_mode_o);
  endtask

  task fire_away;
    sweep = 1;
    cyc(12);
    fire_sw_i = 1;
    seen = 0;
    for (n = 0; n < 20 && stop_near_o !== 1'b1; n++) cyc(1);
    chk("stop_near", 1, stop_near_o);
    sweep = 0;
    for (n = 0; n < 300 && fire_link_o !== 1'b1; n++) begin
      if (door_open_o !== 1'b0) seen = 1;
      cyc(1);
    end
    chk("door_early", 0, seen);
    chk("floor", 0, car_floor_i);
  endtask

  task fire_opt0;
    fire_opt_i = 0;
    fire_sw_i = 0;
    cyc(2);
    fire_sw_i = 1;
    for (n = 0; n < 50 && fire_link_o !== 1'b1; n++) cyc(1);
    cyc(10);
    chk("hold_open", 1, door_open_o);
    car_btn_i = 8'h08;
    cyc(2);
    car_btn_i = 8'h20;
    cyc(2);
    car_btn_i = 8'h00;
    door_close_btn_i = 1;
    cyc(3);
    door_close_btn_i = 0;
    cyc(2);
    chk("reopen", 1, door_open_o);
    cyc(10);
    door_close_btn_i = 1;
    for (n = 0; n < 30 && run_o !== 1'b1; n++) cyc(1);
    chk("tgt", 3, run_tgt_o);
    for (n = 0; n < 100 && (car_floor_i !== 3'h3 || car_moving_i); n++) cyc(1);
    door_close_btn_i = 0;
    cyc(3);
    door_open_btn_i = 1;
    cyc(2);
    door_open_btn_i = 0;
    cyc(2);
    chk("reclose", 1, door_close_o);
    fire_sw_i = 0;
    cyc(3);
  endtask

  task rescue;
    strand = 1;
    fault_i = 1;
    inv_ok_i = 0;
    cyc(1);
    strand = 0;
    cyc(10);
    chk("crawl_bad_inv", 0, crawl_o);
    inv_ok_i = 1;
    for (n = 0; n < 10 && crawl_o !== 1'b1; n++) cyc(1);
    chk("crawl_up", 1, crawl_up_o);
    for (n = 0; n < 50 && door_open_o !== 1'b1; n++) cyc(1);
    chk("zone_open", 1, in_zone_i & door_open_o);
    fault_i = 0;
    cyc(3);
  endtask

  task parking;
    park_lock_i = 1;
    cyc(3);
    chk("park_hall", 0, hall_call_en_o);
    for (n = 0; n < 400 && parking_display_sign_o !== 1'b1; n++) cyc(1);
    chk("park_floor", 1, car_floor_i);
    chk("sign", 1, parking_display_sign_o);
    chk("car_en", 0, car_call_en_o);
    for (n = 0; n < PD + 20 && car_light_o !== 1'b0; n++) cyc(1);
    chk("delay_ok", 1, n >= PD && n <= PD + 2);
    chk("disp", 0, disp_on_o);
    door_open_btn_i = 1;
    cyc(1);
    door_open_btn_i = 0;
    cyc(2);
    chk("light_back", 1, car_light_o);
    for (n = 0; n < PD + 20 && car_light_o !== 1'b0; n++) cyc(1);
    chk("close_again", 1, door_close_o & (n >= PD - 3) & (n <= PD));
    park_lock_i = 0;
    cyc(3);
    chk("unpark", 1, hall_call_en_o & !park_mode_o);
  endtask

  task priority_mix;
    park_lock_i = 1;
    fire_sw_i = 1;
    cyc(4);
    chk("prio", 2, {fire_mode_o, park_mode_o});
    park_lock_i = 0;
    fire_sw_i = 0;
    cyc(3);
  endtask

  task park_insp;
    car_call_pend_i = 1;
    insp_i = 1;
    park_lock_i = 1;
    cyc(6);
    fl = car_floor_i;
    chk("srv_car_en", 1, car_call_en_o);
    chk("srv_sign", 0, parking_display_sign_o);
    car_call_pend_i = 0;
    for (n = 0; n < 20 && parking_display_sign_o !== 1'b1; n++) cyc(1);
    chk("insp_sign", 1, parking_display_sign_o);
    chk("insp_floor", fl, car_floor_i);
    chk("insp_run", 0, run_o);
    park_lock_i = 0;
    insp_i = 0;
    cyc(3);
    chk("insp_exit", 0, park_mode_o);
  endtask

  initial begin
    cyc(20);
    arst_n_i = 1;
    cyc(2);
    fire_return();
    fire_away();
    fire_opt0();
    rescue();
    parking();
    priority_mix();
    park_insp();
    give_verdict();
  end

  initial begin
    #(3000 * 100);
    bad_count++;
    give_verdict();
  end
endmodule // test_lfp_mode_ctrl
